// >>> hw/tmrc_regs.svh
// Register indices, field positions, reset values and timing counts of the timer block
`ifndef TMRC_REGS_SVH
`define TMRC_REGS_SVH
// Register indices; byte address is four times the index
`define TMRC_IDX_FSEL      6'h00
`define TMRC_IDX_CNT_HI    6'h04
`define TMRC_IDX_CNT_LO    6'h05
`define TMRC_IDX_CTL1      6'h06
`define TMRC_IDX_IEN       6'h0C
`define TMRC_IDX_CTL2      6'h0D
`define TMRC_IDX_CHFLG     6'h0E
`define TMRC_IDX_OVFLG     6'h0F
`define TMRC_IDX_VAL_BASE  2'h1
`define TMRC_IDX_ISTAT     6'h30
`define TMRC_IDX_ICLR      6'h31
// Field positions
`define TMRC_CTL1_TEN      7
`define TMRC_CTL1_FFC      4
`define TMRC_CTL2_TOI      7
`define TMRC_CTL2_CRE      3
`define TMRC_OVF_BIT       7
`define TMRC_ISTAT_OVF     8
// Reset values
`define TMRC_RST_8         8'h00
`define TMRC_RST_16        16'h0000
`define TMRC_RST_PSC       7'h00
`define TMRC_CNT_MAX       16'hFFFF
`define TMRC_CNT_ZERO      16'h0000
`define TMRC_PS_MAX        3'h7
`endif

// >>> hw/tmrc_pkg.sv
// Types shared by the timer block
`default_nettype none
package tmrc_pkg;
  // AHB-Lite request side, as seen by the slave
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } tmrc_ahb_req_t;

  // AHB-Lite answer side
  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } tmrc_ahb_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ
  } tmrc_bus_st_t;
endpackage : tmrc_pkg
`default_nettype wire

// >>> hw/tmrc_top.sv
// Eight-channel 16-bit capture/compare timer with AHB-Lite register slave
// Function
// - Channel enable gates same-position channel flag
// - Overflow enable requests interrupt on overflow flag
// - Reset-on-match: channel 7 compare zeroes counter
// - Channel 7 value zero holds counter zero
// - Match-reset wrap at 0xFFFF sets no overflow
// - Prescaler divides bus clock by two^select
// - New prescale applied when prescale counter zero
// - Events set channel flags; write one clears
// - Fast clear: capture read, compare write clears
// - Fast clear: counter access clears overflow flag
// - Overflow flag set on wrap, cleared by one
// - Capture copies counter; compare holds match value
// - Value writes ignored while channel captures
// - Value registers reset to zero
// - Fast clear enable bit in control one
`include "tmrc_regs.svh"
`default_nettype none
module tmrc_top (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // AHB-Lite slave
  input  wire tmrc_pkg::tmrc_ahb_req_t ahb_req_i,
  input  wire logic [31:0]            hwdata_i,
  output var  tmrc_pkg::tmrc_ahb_rsp_t ahb_rsp_o,
  // Capture events, one-cycle pulse per channel on its configured edge
  input  wire logic [7:0]             cap_evt_i,
  // Interrupt
  output logic                        irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic is_val(input logic [5:0] idx);
    return idx[5:4] == `TMRC_IDX_VAL_BASE;
  endfunction : is_val

  function automatic logic [7:0] chan_bit(input logic [5:0] idx);
    return 8'h01 << idx[3:1];
  endfunction : chan_bit

  function automatic logic [6:0] ps_mask(input logic [2:0] sel);
    logic [7:0] m;
    m = (8'h01 << sel) - 8'h01;
    return m[6:0];
  endfunction : ps_mask

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  tmrc_pkg::tmrc_bus_st_t st_ff;
  tmrc_pkg::tmrc_bus_st_t nxt_st;
  logic [5:0]  idx_ff;
  logic [31:0] hrdata_ff;
  logic        hready_ff;
  logic [7:0]  fsel_ff;
  logic [7:0]  ctl1_ff;
  logic [7:0]  ien_ff;
  logic [7:0]  ctl2_ff;
  logic [2:0]  act_ps_ff;
  logic [6:0]  psc_ff;
  logic [15:0] cnt_ff;
  logic [7:0]  chf_ff;
  logic        tof_ff;
  logic [15:0] val_ff [8];
  logic        irq_ff;
  logic        hresp_ff;

  // Register map, byte address is four times the index:
  //   0x00       channel function select, 1 = compare, 0 = capture
  //   0x04, 0x05 free running counter, read only
  //   0x06       control one: bit 7 timer enable, bit 4 fast flag clear
  //   0x0C       channel interrupt enables, one per channel flag
  //   0x0D       control two: bit 7 overflow irq enable, bit 3 reset on match,
  //              bits 2:0 prescale select
  //   0x0E       channel flags, write one to clear
  //   0x0F       overflow flag in bit 7, write one to clear
  //   0x10..0x1F channel values; both indices of a channel reach the same word
  //   0x30       interrupt status, read only: bit 8 overflow, bits 7:0 channel flags
  //   0x31       interrupt clear, write only, same layout as the status
  // Unmapped indices read zero and ignore writes; every answer is OKAY.

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire        acc_ok  = ahb_req_i.hsel & ahb_req_i.htrans[1] & ahb_req_i.hready;
  wire        wr_do   = (st_ff == tmrc_pkg::ST_WRITE);
  wire        rd_do   = (st_ff == tmrc_pkg::ST_READ);
  wire        acc_do  = wr_do | rd_do;
  wire [7:0]  wd8     = hwdata_i[7:0];
  wire        wr_fsel = wr_do & (idx_ff == `TMRC_IDX_FSEL);
  wire        wr_ctl1 = wr_do & (idx_ff == `TMRC_IDX_CTL1);
  wire        wr_ien  = wr_do & (idx_ff == `TMRC_IDX_IEN);
  wire        wr_ctl2 = wr_do & (idx_ff == `TMRC_IDX_CTL2);
  wire        wr_chf  = wr_do & (idx_ff == `TMRC_IDX_CHFLG);
  wire        wr_ovf  = wr_do & (idx_ff == `TMRC_IDX_OVFLG);
  wire        wr_iclr = wr_do & (idx_ff == `TMRC_IDX_ICLR);
  wire        cnt_sel = (idx_ff == `TMRC_IDX_CNT_HI) | (idx_ff == `TMRC_IDX_CNT_LO);
  wire        val_sel = is_val(idx_ff);
  wire [7:0]  vbit    = val_sel ? chan_bit(idx_ff) : 8'h00;
  wire        ffc     = ctl1_ff[`TMRC_CTL1_FFC];
  wire        ten     = ctl1_ff[`TMRC_CTL1_TEN];
  wire        cre     = ctl2_ff[`TMRC_CTL2_CRE];

  assign nxt_st = acc_ok ? (ahb_req_i.hwrite ? tmrc_pkg::ST_WRITE : tmrc_pkg::ST_READ)
                         : tmrc_pkg::ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and counter
  // Prescale counter only runs while enabled, so a stopped timer takes a new
  // select at once; a running one waits for the all-zero point
  wire        tick    = ten & ((psc_ff & ps_mask(act_ps_ff)) == `TMRC_RST_PSC);
  wire        match7  = (cnt_ff == val_ff[7]) & fsel_ff[7];
  wire        mreset  = tick & cre & match7;
  wire        wrap    = tick & ~mreset & (cnt_ff == `TMRC_CNT_MAX);
  wire [15:0] nxt_cnt = mreset ? `TMRC_CNT_ZERO : cnt_ff + 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // Channel events and flags
  wire [7:0] cmp_hit;
  wire [7:0] cap_hit = cap_evt_i & ~fsel_ff;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_cmp
      assign cmp_hit[g] = tick & fsel_ff[g] & (cnt_ff == val_ff[g]);
    end
  endgenerate
  // Fast clear looks at the channel mode, so a capture channel is never
  // cleared by a write and a compare channel never by a read
  wire [7:0] set_ch   = cmp_hit | cap_hit;
  wire [7:0] fast_clr = ffc ? (vbit & ((rd_do ? ~fsel_ff : 8'h00)
                                     | (wr_do ? fsel_ff : 8'h00))) : 8'h00;
  wire [7:0] clr_ch   = (wr_chf ? wd8 : 8'h00) | (wr_iclr ? wd8 : 8'h00) | fast_clr;
  // Set wins over clear so an event in the clearing cycle is kept
  wire [7:0] nxt_chf  = (chf_ff & ~clr_ch) | set_ch;
  wire       clr_tof  = (wr_ovf & hwdata_i[`TMRC_OVF_BIT])
                      | (wr_iclr & hwdata_i[`TMRC_ISTAT_OVF])
                      | (ffc & acc_do & cnt_sel);
  wire       nxt_tof  = (tof_ff & ~clr_tof) | wrap;
  wire       nxt_irq  = (|(nxt_chf & ien_ff))
                      | (nxt_tof & ctl2_ff[`TMRC_CTL2_TOI]);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (val_sel) begin
      rd_mux = {16'h0000, val_ff[idx_ff[3:1]]};
    end else begin
      case (idx_ff)
        `TMRC_IDX_FSEL:   rd_mux = {24'h000000, fsel_ff};
        `TMRC_IDX_CNT_HI,
        `TMRC_IDX_CNT_LO: rd_mux = {16'h0000, cnt_ff};
        `TMRC_IDX_CTL1:   rd_mux = {24'h000000, ctl1_ff};
        `TMRC_IDX_IEN:    rd_mux = {24'h000000, ien_ff};
        `TMRC_IDX_CTL2:   rd_mux = {24'h000000, ctl2_ff};
        `TMRC_IDX_CHFLG:  rd_mux = {24'h000000, chf_ff};
        `TMRC_IDX_OVFLG:  rd_mux = {24'h000000, tof_ff, 7'h00};
        `TMRC_IDX_ISTAT:  rd_mux = {23'h000000, tof_ff, chf_ff};
        default:          rd_mux = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave registers
  // Reads take one wait state so that read data comes from a flip-flop
  // Writes need none: the data phase lands at the edge that ends it.
  // Read side effects (fast flag clear) happen at the edge that loads hrdata,
  // which then holds until the next read.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff     <= tmrc_pkg::ST_IDLE;
      idx_ff    <= 6'h00;
      hready_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
      hresp_ff  <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      idx_ff    <= acc_ok ? ahb_req_i.haddr[7:2] : idx_ff;
      hready_ff <= ~(acc_ok & ~ahb_req_i.hwrite);
      hrdata_ff <= rd_do ? rd_mux : hrdata_ff;
      hresp_ff  <= 1'b0;
    end
  end

  assign ahb_rsp_o.hrdata    = hrdata_ff;
  assign ahb_rsp_o.hreadyout = hready_ff;
  assign ahb_rsp_o.hresp     = hresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fsel_ff <= `TMRC_RST_8;
      ctl1_ff <= `TMRC_RST_8;
      ien_ff  <= `TMRC_RST_8;
      ctl2_ff <= `TMRC_RST_8;
    end else begin
      fsel_ff <= wr_fsel ? wd8 : fsel_ff;
      ctl1_ff <= wr_ctl1 ? wd8 : ctl1_ff;
      ien_ff  <= wr_ien ? wd8 : ien_ff;
      ctl2_ff <= wr_ctl2 ? wd8 : ctl2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler, counter, flags, interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psc_ff    <= `TMRC_RST_PSC;
      act_ps_ff <= 3'h0;
      cnt_ff    <= `TMRC_CNT_ZERO;
      chf_ff    <= `TMRC_RST_8;
      tof_ff    <= 1'b0;
      irq_ff    <= 1'b0;
    end else begin
      psc_ff    <= ten ? psc_ff + 7'h01 : `TMRC_RST_PSC;
      act_ps_ff <= (psc_ff == `TMRC_RST_PSC) ? ctl2_ff[2:0] : act_ps_ff;
      cnt_ff    <= tick ? nxt_cnt : cnt_ff;
      chf_ff    <= nxt_chf;
      tof_ff    <= nxt_tof;
      irq_ff    <= nxt_irq;
    end
  end

  assign irq_o = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Channel value registers
  generate
    for (g = 0; g < 8; g++) begin : g_val
      wire wr_v = wr_do & vbit[g] & fsel_ff[g];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          val_ff[g] <= `TMRC_RST_16;
        end else if (cap_hit[g]) begin
          val_ff[g] <= cnt_ff;
        end else if (wr_v) begin
          val_ff[g] <= hwdata_i[15:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_IRQ_CH: assert property ((|(nxt_chf & ien_ff)) |=> irq_o)
    else $error("enabled channel flag did not raise interrupt");
  AST_IRQ_OVF: assert property (nxt_tof & ctl2_ff[`TMRC_CTL2_TOI] |=> irq_o)
    else $error("enabled overflow flag did not raise interrupt");
  AST_NO_IRQ: assert property (!nxt_tof && (nxt_chf & ien_ff) == 8'h00 |=> !irq_o)
    else $error("interrupt without enabled flag");
  AST_CRE: assert property (tick && cre && fsel_ff[7] && cnt_ff == val_ff[7]
                            |=> cnt_ff == 16'h0000)
    else $error("counter not reset on channel 7 match");
  AST_HOLD0: assert property (cre && fsel_ff[7] && val_ff[7] == 16'h0000
                              && cnt_ff == 16'h0000 && !cap_hit[7] && !wr_do
                              |=> cnt_ff == 16'h0000)
    else $error("counter left zero with zero match value");
  AST_NO_TOF: assert property (tick && cre && fsel_ff[7] && val_ff[7] == 16'hFFFF
                               && cnt_ff == 16'hFFFF && !tof_ff |=> !tof_ff)
    else $error("overflow flag set by match reset");
  AST_DIV128: assert property (tick && act_ps_ff == 3'h7
                               && ctl2_ff[2:0] == 3'h7 |=> !tick [*7])
    else $error("divide by 128 ticked too early");
  AST_PS_DEFER: assert property (psc_ff != 7'h00 |=> act_ps_ff == $past(act_ps_ff))
    else $error("prescale changed mid count");
  AST_W0_KEEP: assert property (wr_chf && wd8 == 8'h00 && fast_clr == 8'h00
                                |=> (chf_ff & $past(chf_ff)) == $past(chf_ff))
    else $error("writing zero cleared a channel flag");
  AST_FAST_CH: assert property ((fast_clr & ~set_ch) != 8'h00
                                |=> (chf_ff & $past(fast_clr & ~set_ch)) == 8'h00)
    else $error("fast clear missed a channel flag");
  AST_FAST_OVF: assert property (ffc && acc_do && cnt_sel && !wrap |=> !tof_ff)
    else $error("counter access did not clear overflow flag");
  AST_TOF_SET: assert property (wrap |=> tof_ff && cnt_ff == 16'h0000)
    else $error("wrap did not set overflow flag");
  AST_CAP: assert property (cap_hit[0] |=> val_ff[0] == $past(cnt_ff))
    else $error("capture did not copy counter");
  AST_CAP_WR: assert property (wr_do && vbit[1] && !fsel_ff[1] && !cap_hit[1]
                               |=> $stable(val_ff[1]))
    else $error("write changed a capture value");
  AST_INC: assert property (tick && !mreset |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("counter did not step by one");
  AST_RD_WAIT: assert property (acc_ok && !ahb_req_i.hwrite
                                |=> !ahb_rsp_o.hreadyout ##1 ahb_rsp_o.hreadyout)
    else $error("read wait state wrong");
  AST_WR_NOWAIT: assert property (acc_ok && ahb_req_i.hwrite
                                  |=> ahb_rsp_o.hreadyout)
    else $error("write inserted a wait state");

  // Capture and compare values
  AST_CAP1: assert property (cap_hit[1] |=> val_ff[1] == $past(cnt_ff))
    else $error("capture on channel 1 did not copy counter");
  AST_CAP_CMP_IGN: assert property (cap_evt_i[1] && fsel_ff[1] && !(wr_do && vbit[1])
                                    |=> $stable(val_ff[1]))
    else $error("capture event changed a compare value");
  AST_CMP_WR: assert property (wr_do && vbit[7] && fsel_ff[7]
                               |=> val_ff[7] == $past(hwdata_i[15:0]))
    else $error("compare value write not taken");

  // Channel flags
  AST_CH_SET: assert property (set_ch != 8'h00
                               |=> (chf_ff & $past(set_ch)) == $past(set_ch))
    else $error("event did not set its channel flag");
  AST_W1C: assert property (wr_chf && (wd8 & ~set_ch) != 8'h00
                            |=> (chf_ff & $past(wd8 & ~set_ch)) == 8'h00)
    else $error("writing one did not clear a channel flag");
  AST_CH_ONLY_EVT: assert property (1'b1
                                    |=> (chf_ff & ~$past(chf_ff | set_ch)) == 8'h00)
    else $error("channel flag rose without an event");
  AST_CAP_FLAG: assert property (cap_hit[1] |=> chf_ff[1])
    else $error("capture did not set channel 1 flag");
  AST_CMP_FLAG: assert property (cmp_hit[7] |=> chf_ff[7])
    else $error("compare did not set channel 7 flag");

  // Fast flag clearing
  AST_FAST_CAP_RD: assert property (ffc && rd_do && vbit[1] && !fsel_ff[1] && !cap_hit[1]
                                    |=> !chf_ff[1])
    else $error("capture read did not fast clear");
  AST_FAST_CMP_WR: assert property (ffc && wr_do && vbit[7] && fsel_ff[7] && !cmp_hit[7]
                                    |=> !chf_ff[7])
    else $error("compare write did not fast clear");
  AST_NO_FAST: assert property (!ffc && !wr_chf && !wr_iclr
                                |=> (chf_ff & $past(chf_ff)) == $past(chf_ff))
    else $error("channel flag cleared without a flag write");
  AST_NO_FAST_OVF: assert property (!ffc && !wr_ovf && !wr_iclr && tof_ff
                                    |=> tof_ff)
    else $error("overflow flag cleared without a flag write");

  // Overflow flag
  AST_OVF_W1C: assert property (wr_ovf && hwdata_i[7] && !wrap |=> !tof_ff)
    else $error("writing one did not clear overflow flag");
  AST_OVF_W0: assert property (wr_ovf && !hwdata_i[7] && tof_ff
                               |=> tof_ff)
    else $error("writing zero cleared overflow flag");
  AST_ISTAT_CLR: assert property (wr_iclr && hwdata_i[8] && !wrap |=> !tof_ff)
    else $error("interrupt clear missed overflow flag");
  AST_TOF_ONLY_WRAP: assert property (!wrap && !tof_ff |=> !tof_ff)
    else $error("overflow flag set without a wrap");

  // Counter and prescaler
  AST_FREE_RUN: assert property (tick && !cre && cnt_ff == 16'hFFFF
                                 |=> cnt_ff == 16'h0000 && tof_ff)
    else $error("free running wrap wrong");
  AST_HOLD_TOF: assert property (cre && fsel_ff[7] && val_ff[7] == 16'h0000
                                 && cnt_ff == 16'h0000 && !tof_ff |=> !tof_ff)
    else $error("held counter set overflow flag");
  AST_STOP: assert property (!ten |=> $stable(cnt_ff))
    else $error("counter moved while timer disabled");
  AST_CNT_RO: assert property (wr_do && cnt_sel && !tick
                               |=> $stable(cnt_ff))
    else $error("counter changed by a bus write");
  AST_DIV1: assert property (ten && act_ps_ff == 3'h0 |-> tick)
    else $error("divide by one missed a tick");
  AST_ACT_PS_LOAD: assert property (psc_ff == 7'h00
                                    |=> act_ps_ff == $past(ctl2_ff[2:0]))
    else $error("prescale select not taken at zero point");
  AST_PS_STOP: assert property (!ten |=> psc_ff == 7'h00)
    else $error("prescale counter ran while timer disabled");

endmodule : tmrc_top
`default_nettype wire

// >>> tb/tmrc_top_tb_top.sv
// Self-checking bench of the timer register block
`default_nettype none
module tmrc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [5:0]  idx;
    logic [31:0] wd;
    logic [31:0] ex;
  } tmrc_tb_row_t;
  logic                    clk_i     = 1'b0;
  logic                    rst_i     = 1'b1;
  tmrc_pkg::tmrc_ahb_req_t req       = '0;
  tmrc_pkg::tmrc_ahb_req_t bus_req;
  tmrc_pkg::tmrc_ahb_rsp_t rsp;
  logic [31:0]             hwdata    = 32'h0;
  logic [7:0]              cap_evt   = 8'h00;
  logic                    irq;
  logic [31:0]             rd;
  logic [15:0]             cnt_a;
  logic [15:0]             dlt;
  int                      bad_count = 0;
  int                      tests_run = 0;
  int                      n;
  // Write then read back; order matters, later rows rely on earlier ones
  tmrc_tb_row_t            rows [13] = '{
    '{6'h0D, 32'h8F, 32'h8F}, '{6'h0D, 32'h00, 32'h00}, '{6'h0C, 32'hA5, 32'hA5},
    '{6'h0C, 32'h00, 32'h00}, '{6'h0E, 32'hFF, 32'h00}, '{6'h0F, 32'h80, 32'h00},
    '{6'h10, 32'h1234, 32'h0}, '{6'h00, 32'hF0, 32'hF0}, '{6'h1E, 32'hABCD, 32'hABCD},
    '{6'h1F, 32'h0, 32'h0}, '{6'h05, 32'h1234, 32'h0}, '{6'h3F, 32'hFFFFFFFF, 32'h0},
    '{6'h30, 32'hFF, 32'h0}};

  always #5 clk_i = ~clk_i;
  // The only slave, so its ready is the bus ready
  assign bus_req = {req[39:1], rsp.hreadyout};

  tmrc_top dut_u (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ahb_req_i (bus_req),
    .hwdata_i  (hwdata),
    .ahb_rsp_o (rsp),
    .cap_evt_i (cap_evt),
    .irq_o     (irq)
  );

  ////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
      bad_count++;
    end
  endtask : chk

  // Single word transfer; waits on ready with no assumed latency
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    req <= '{hsel:1'b1, haddr:{24'h0, idx, 2'h0}, htrans:2'h2, hwrite:w, hsize:3'h2,
             hready:1'b1};
    do @(posedge clk_i); while (rsp.hreadyout !== 1'b1);
    req    <= '0;
    hwdata <= wd;
    do @(posedge clk_i); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask : xfer

  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd);
  endtask : wr

  task automatic rdc(input logic [5:0] idx, input logic [31:0] ex, input string nm);
    xfer(1'b0, idx, 32'h0);
    chk(nm, ex, rd);
    chk("hresp", 32'h0, {31'h0, rsp.hresp});
  endtask : rdc

  // Interrupt flop lags its cause by one edge
  task automatic irqc(input logic ex);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, ex}, {31'h0, irq});
  endtask : irqc

  task automatic cap(input logic [7:0] m);
    cap_evt <= m;
    @(posedge clk_i);
    cap_evt <= 8'h00;
    @(posedge clk_i);
  endtask : cap

  ////////////////////////////////////////
  initial begin
    repeat (95000) @(posedge clk_i);
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) rdc(6'h10 + 6'(2 * i), 32'h0, "value reset");
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rdc(rows[i].idx, rows[i].ex, "row");
    end
    // Capture with the counter frozen so the expected value is known
    wr(6'h06, 32'h80);
    repeat (40) @(posedge clk_i);
    wr(6'h06, 32'h00);
    xfer(1'b0, 6'h05, 32'h0);
    cnt_a = rd[15:0];
    // Compare channels matched at count zero while running; start clean
    wr(6'h0E, 32'hFF);
    cap(8'h02);
    rdc(6'h12, {16'h0, cnt_a}, "captured value");
    rdc(6'h0E, 32'h02, "channel flags");
    rdc(6'h30, 32'h002, "irq status");
    irqc(1'b0);
    wr(6'h0C, 32'h02);
    irqc(1'b1);
    wr(6'h0C, 32'hFD);
    irqc(1'b0);
    wr(6'h0E, 32'h00);
    rdc(6'h0E, 32'h02, "zero write");
    wr(6'h31, 32'h002);
    rdc(6'h0E, 32'h00, "irq clear");
    cap(8'h02);
    xfer(1'b0, 6'h12, 32'h0);
    rdc(6'h0E, 32'h02, "no fast clear");
    wr(6'h06, 32'h10);
    xfer(1'b0, 6'h12, 32'h0);
    rdc(6'h0E, 32'h00, "fast clear read");
    // Reset on match: a fresh reset puts the counter and channel 7 value at zero
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wr(6'h00, 32'hF0);
    wr(6'h0C, 32'h00);
    wr(6'h0D, 32'h08);
    wr(6'h06, 32'h90);
    repeat (20) @(posedge clk_i);
    rdc(6'h05, 32'h0, "held counter");
    wr(6'h1E, 32'h5);
    repeat (30) @(posedge clk_i);
    wr(6'h06, 32'h10);
    xfer(1'b0, 6'h05, 32'h0);
    chk("modulus count", 32'h1, {31'h0, rd < 32'h6});
    wr(6'h1E, 32'h5);
    rdc(6'h0E, 32'h70, "fast clear write");
    wr(6'h0E, 32'hFF);
    // Each select over a fixed window; a few extra edges come from the bus writes
    for (int p = 0; p < 8; p++) begin
      wr(6'h0D, 32'(p));
      xfer(1'b0, 6'h05, 32'h0);
      cnt_a = rd[15:0];
      wr(6'h06, 32'h80);
      repeat (1024) @(posedge clk_i);
      wr(6'h06, 32'h00);
      xfer(1'b0, 6'h05, 32'h0);
      dlt = rd[15:0] - cnt_a;
      chk("ticks", 32'h1, {31'h0, dlt >= (1024 >> p) && dlt <= (1024 >> p) + 3});
    end
    // Full wrap at divide by one
    wr(6'h0E, 32'hFF);
    wr(6'h0D, 32'h80);
    wr(6'h06, 32'h80);
    n = 0;
    while (irq !== 1'b1 && n < 70000) begin
      @(posedge clk_i);
      n++;
    end
    chk("overflow irq", 32'h1, {31'h0, irq});
    rdc(6'h0F, 32'h80, "overflow flag");
    wr(6'h0D, 32'h00);
    irqc(1'b0);
    wr(6'h0F, 32'h00);
    rdc(6'h0F, 32'h80, "overflow zero write");
    wr(6'h06, 32'h90);
    xfer(1'b0, 6'h04, 32'h0);
    rdc(6'h0F, 32'h00, "counter access");
    // Second reset in mid-run
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(6'h1E, 32'h0, "value after reset");
    wrap_up();
  end
endmodule : tmrc_top_tb_top
`default_nettype wire
